// ===== rtl/srw_top.v
/*
  Stop recovery and watchdog block: wake source selection, warm/cold flag,
  recovery delay and a retriggerable watchdog, with an AXI4-Lite slave.
  Assumes pins and the RC oscillator tick arrive asynchronously and that the
  core reports halt, stop and refresh through the core control register.
*/
// Implementation choice: the AXI4-Lite register port.
// Contract
// - Source code 000 is power-on only; 001..101 pick p3 lines 0..3 or p2 line 7.
// - Code 110 wakes on NOR of port2 lines 0..3; 111 on NOR of 0..7.
// - Delay bit set inserts 5 ms reset delay after wake; resets to one.
// - Level bit one wakes on high, zero on low; resets to zero.
// - Warm flag is set on stop entry; zero means cold power-on.
// - Extra register 01 wakes on AND of port2 0..3, 10 on 0..7.
// - Watchdog is a retriggerable one-shot that resets the processor at terminal count.
// - Watchdog off after power-on; first refresh enables, later refreshes restart.
// - Refresh also modifies the core's zero, sign and overflow flags.
// - RC clock time-outs: 5, 10, 20, 80 ms for codes 00..11.
// - System clock time-outs: 128, 256, 512, 2048 cycles.
// - Time-out field resets to code 01.
// - Mode bit 2 keeps watchdog counting in halt; resets to one.
// - Mode bit 3 keeps watchdog running in stop, only with RC clock.
// - Mode bit 4 picks crystal clock; watchdog then stops in stop mode.
// - Permanent option enables watchdog from reset in run and halt regardless.
// - Watchdog time-out in stop keeps recovery and mode registers intact.
// - Watchdog mode writes accepted only in first 60 clocks after reset.
// - Recovery bit 1 selects undivided system clock; resets to zero.
// - Recovery bits write-only except read-only bit 7, cleared only by power-on.
// - Port2 pins driven as outputs are sampled at their driven level.
`timescale 1ns/1ps
`include "srw_defines.vh"

module srw_top #(
  parameter DELAY_CYC = `SRW_DELAY_US * `SRW_CLK_MHZ,
  parameter WD_CYC0   = `SRW_WD_T0_US * `SRW_CLK_MHZ,
  parameter WD_CYC1   = `SRW_WD_T1_US * `SRW_CLK_MHZ,
  parameter WD_CYC2   = `SRW_WD_T2_US * `SRW_CLK_MHZ,
  parameter WD_CYC3   = `SRW_WD_T3_US * `SRW_CLK_MHZ,
  parameter PERMANENT = 0
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        por_n,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  input  wire [3:0]  port3_in,
  input  wire [7:0]  port2_in,
  input  wire [7:0]  port2_out,
  input  wire [7:0]  port2_oe,
  input  wire [3:1]  port3_analog,
  input  wire        rc_tick,
  input  wire        xtal_tick,
  output reg         wake,
  output reg         core_reset,
  output reg         flags_update,
  output reg         clk_undivided,
  output reg         clk_div16
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  wire [7:0] p2_level = (port2_oe & port2_out) | (~port2_oe & port2_in);
  reg  [13:0] pin_s1_q;
  reg  [13:0] pin_s2_q;
  reg         por_s1_q;
  reg         por_s2_q;
  reg         rc_prev_q;
  reg         xt_prev_q;

  always @(posedge aclk) begin
    pin_s1_q <= {xtal_tick, rc_tick, p2_level, port3_in};
    pin_s2_q <= pin_s1_q;
    por_s1_q <= por_n;
    por_s2_q <= por_s1_q;
    rc_prev_q <= pin_s2_q[12];
    xt_prev_q <= pin_s2_q[13];
  end

  wire [3:0] p3_s   = pin_s2_q[3:0];
  wire [7:0] p2_s   = pin_s2_q[11:4];
  wire       rc_ev  = pin_s2_q[12] & ~rc_prev_q;
  wire       xt_ev  = pin_s2_q[13] & ~xt_prev_q;
  wire       por_ok = por_s2_q;

  // ==========================================================================
  // Registers
  // ==========================================================================
  reg [6:0]  rec_q;
  reg        warm_q;
  reg [1:0]  recx_q;
  reg [4:0]  wm_q;
  reg        halt_q;
  reg        stop_q;
  reg        wd_on_q;
  reg [31:0] wd_cnt_q;
  reg [7:0]  win_q;
  reg [31:0] dly_q;
  reg        dly_on_q;
  reg [2:0]  pulse_q;
  reg        wd_fired_q;

  wire aw_ok = awvalid & wvalid & ~bvalid;
  wire wr_en = aw_ok & wstrb[0];
  wire [7:0] wb = wdata[7:0];
  wire [7:0] widx = {2'b00, awaddr[7:2]};
  wire wr_rec  = wr_en & (widx == `SRW_IDX_RECOVERY);
  wire wr_recx = wr_en & (widx == `SRW_IDX_RECOVERY_X);
  wire wr_wm   = wr_en & (widx == `SRW_IDX_WD_MODE) & (win_q < `SRW_WM_WINDOW);
  wire wr_core = wr_en & (widx == `SRW_IDX_CORE);
  wire refresh = wr_core & wb[`SRW_CC_REFRESH];
  wire map_ok  = (widx == `SRW_IDX_RECOVERY) | (widx == `SRW_IDX_RECOVERY_X) |
                 (widx == `SRW_IDX_WD_MODE) | (widx == `SRW_IDX_CORE);

  // ==========================================================================
  // Wake detection
  // ==========================================================================
  reg src_act;
  always @* begin
    case (rec_q[4:2])
      3'h1: src_act = p3_s[0];
      3'h2: src_act = p3_s[1] & ~port3_analog[1];
      3'h3: src_act = p3_s[2] & ~port3_analog[2];
      3'h4: src_act = p3_s[3] & ~port3_analog[3];
      3'h5: src_act = p2_s[7];
      3'h6: src_act = ~(|p2_s[3:0]);
      3'h7: src_act = ~(|p2_s);
      default: src_act = 1'b0;
    endcase
  end

  // The extra register is only consulted when the main source field is zero,
  // so a stray write there never overrides the main selection.
  reg srcx_act;
  always @* begin
    case (recx_q)
      2'h1: srcx_act = &p2_s[3:0];
      2'h2: srcx_act = &p2_s;
      default: srcx_act = 1'b0;
    endcase
  end

  // Level inversion only applies to single-pin sources; NOR/AND are fixed.
  wire lvl_hit = (rec_q[4:2] == 3'h0) ? 1'b0 :
                 (rec_q[4:2] >= 3'h6) ? src_act :
                 (src_act == rec_q[`SRW_RC_LEVEL]);
  wire wake_hit = lvl_hit | ((rec_q[4:2] == 3'h0) & srcx_act);

  // ==========================================================================
  // Watchdog
  // ==========================================================================
  reg [31:0] wd_limit;
  always @* begin
    if (wm_q[`SRW_WM_XTAL]) begin
      case (wm_q[1:0])
        2'h0: wd_limit = `SRW_SCLK_T0;
        2'h1: wd_limit = `SRW_SCLK_T1;
        2'h2: wd_limit = `SRW_SCLK_T2;
        default: wd_limit = `SRW_SCLK_T3;
      endcase
    end else begin
      case (wm_q[1:0])
        2'h0: wd_limit = WD_CYC0;
        2'h1: wd_limit = WD_CYC1;
        2'h2: wd_limit = WD_CYC2;
        default: wd_limit = WD_CYC3;
      endcase
    end
  end

  wire perm    = (PERMANENT != 0);
  wire wd_tick = wm_q[`SRW_WM_XTAL] ? xt_ev : 1'b1;
  wire run_ok  = stop_q ? (~wm_q[`SRW_WM_XTAL] & (perm | wm_q[`SRW_WM_STOP])) :
                 halt_q ? (perm | wm_q[`SRW_WM_HALT]) : 1'b1;
  wire wd_hit  = wd_on_q & run_ok & wd_tick & (wd_cnt_q + 32'h1 >= wd_limit);

  // ==========================================================================
  // Sequential state
  // ==========================================================================
  always @(posedge aclk) begin
    if (!aresetn) begin
      win_q      <= 8'h00;
      halt_q     <= 1'b0;
      stop_q     <= 1'b0;
      wd_on_q    <= perm;
      wd_cnt_q   <= 32'h0;
      dly_q      <= 32'h0;
      dly_on_q   <= 1'b0;
      pulse_q    <= 3'h0;
      wake       <= 1'b0;
      core_reset <= 1'b0;
      flags_update <= 1'b0;
      wd_fired_q <= 1'b0;
    end else begin
      if (win_q < `SRW_WM_WINDOW)
        win_q <= win_q + 8'h01;
      flags_update <= refresh;
      wake <= 1'b0;
      if (wr_core) begin
        halt_q <= wb[`SRW_CC_HALT];
        stop_q <= wb[`SRW_CC_STOP];
      end
      if (stop_q & wake_hit & ~wr_core) begin
        stop_q <= 1'b0;
        halt_q <= 1'b0;
        wake   <= ~rec_q[`SRW_RC_DELAY];
        dly_on_q <= rec_q[`SRW_RC_DELAY];
        dly_q  <= 32'h0;
      end
      if (dly_on_q) begin
        dly_q <= dly_q + 32'h1;
        if (dly_q + 32'h1 >= DELAY_CYC) begin
          dly_on_q <= 1'b0;
          wake     <= 1'b1;
        end
      end
      if (refresh) begin
        wd_on_q  <= 1'b1;
        wd_cnt_q <= 32'h0;
      end else if (wd_hit) begin
        wd_cnt_q <= 32'h0;
        pulse_q  <= `SRW_RST_PULSE;
        wd_fired_q <= 1'b1;
        stop_q   <= 1'b0;
      end else if (wd_on_q & run_ok & wd_tick) begin
        wd_cnt_q <= wd_cnt_q + 32'h1;
      end
      if (pulse_q != 3'h0)
        pulse_q <= pulse_q - 3'h1;
      core_reset <= (pulse_q != 3'h0) | wd_hit;
    end
  end

  // Configuration registers reset only on power-on, so a watchdog reset
  // taken in stop leaves the wake setup intact.
  always @(posedge aclk) begin
    if (!por_ok) begin
      rec_q  <= `SRW_RC_RESET;
      warm_q <= 1'b0;
      recx_q <= `SRW_RCX_RESET;
      wm_q   <= `SRW_WM_RESET;
    end else begin
      if (wr_rec)
        rec_q <= wb[6:0];
      if (wr_recx)
        recx_q <= wb[1:0];
      if (wr_wm)
        wm_q <= wb[4:0];
      if (wr_core & wb[`SRW_CC_STOP])
        warm_q <= 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!por_ok) begin
      clk_undivided <= 1'b0;
      clk_div16     <= 1'b0;
    end else begin
      clk_undivided <= rec_q[`SRW_RC_DIV2];
      clk_div16     <= rec_q[`SRW_RC_DIV16];
    end
  end

  // ==========================================================================
  // AXI4-Lite slave
  // ==========================================================================
  wire [7:0] ridx = {2'b00, araddr[7:2]};
  reg  [7:0] rd_val;
  reg        rd_ok;
  always @* begin
    rd_ok  = 1'b1;
    rd_val = 8'h00;
    case (ridx)
      `SRW_IDX_RECOVERY:   rd_val = {warm_q, 7'h00};
      `SRW_IDX_RECOVERY_X: rd_val = 8'h00;
      `SRW_IDX_WD_MODE:    rd_val = 8'h00;
      `SRW_IDX_CORE:       rd_val = {5'h00, stop_q, halt_q, 1'b0};
      `SRW_IDX_STATUS:     rd_val = {4'h0, wd_fired_q, dly_on_q,
                                     (win_q < `SRW_WM_WINDOW), wd_on_q};
      default:             rd_ok  = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= 2'h0;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rresp   <= 2'h0;
      rdata   <= 32'h0;
    end else begin
      awready <= 1'b0;
      wready  <= 1'b0;
      arready <= 1'b0;
      if (aw_ok & ~awready) begin
        awready <= 1'b1;
        wready  <= 1'b1;
        bvalid  <= 1'b1;
        bresp   <= map_ok ? 2'h0 : 2'h2;
      end else if (bvalid & bready) begin
        bvalid <= 1'b0;
      end
      if (arvalid & ~rvalid & ~arready) begin
        arready <= 1'b1;
        rvalid  <= 1'b1;
        rdata   <= {24'h0, rd_val};
        rresp   <= rd_ok ? 2'h0 : 2'h2;
      end else if (rvalid & rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule

// ===== common/srw_defines.vh
/*
  Offsets, field positions, reset values and timing counts for the stop
  recovery and watchdog block. Assumes a 200 MHz aclk and byte addressing
  on a 32-bit AXI4-Lite bus.
*/
`ifndef SRW_DEFINES_VH
`define SRW_DEFINES_VH

// ==========================================================================
// Register map
// ==========================================================================
`define SRW_IDX_RECOVERY     8'h0B
`define SRW_IDX_RECOVERY_X   8'h0C
`define SRW_IDX_WD_MODE      8'h0F
`define SRW_IDX_CORE         8'h10
`define SRW_IDX_STATUS       8'h11
`define SRW_ADDR_W           8

// ==========================================================================
// Recovery register fields and reset values
// ==========================================================================
`define SRW_RC_DIV16         0
`define SRW_RC_DIV2          1
`define SRW_RC_SRC_LO        2
`define SRW_RC_DELAY         5
`define SRW_RC_LEVEL         6
`define SRW_RC_WARM          7
`define SRW_RC_RESET         7'h20
`define SRW_RCX_RESET        2'h0

// ==========================================================================
// Watchdog mode fields and reset values
// ==========================================================================
`define SRW_WM_HALT          2
`define SRW_WM_STOP          3
`define SRW_WM_XTAL          4
`define SRW_WM_RESET         5'h05

// ==========================================================================
// Core control register bits
// ==========================================================================
`define SRW_CC_REFRESH       0
`define SRW_CC_HALT          1
`define SRW_CC_STOP          2

// ==========================================================================
// Timing
// ==========================================================================
`define SRW_CLK_MHZ          200
`define SRW_DELAY_US         5000
`define SRW_WD_T0_US         5000
`define SRW_WD_T1_US         10000
`define SRW_WD_T2_US         20000
`define SRW_WD_T3_US         80000
`define SRW_SCLK_T0          128
`define SRW_SCLK_T1          256
`define SRW_SCLK_T2          512
`define SRW_SCLK_T3          2048
`define SRW_WM_WINDOW        60
`define SRW_FAST_HOLD        5
`define SRW_RST_PULSE        3'h4

`endif

// ===== bench/srw_checker.sv
/*
  Concurrent checks on the ports of srw_top.
  Assumes one clock, aclk, with the synchronous active-low reset aresetn.
*/
`timescale 1ns/1ps
module srw_checker #(
  parameter WD_CYC0 = 30,
  parameter WD_CYC3 = 60
) (
  input logic aclk,
  input logic aresetn,
  input logic awvalid,
  input logic wvalid,
  input logic awready,
  input logic wready,
  input logic bvalid,
  input logic bready,
  input logic arvalid,
  input logic arready,
  input logic rvalid,
  input logic rready,
  input logic wake,
  input logic core_reset,
  input logic flags_update
);
  // ====================
  // Helper state
  // ====================
  // The period is counted from the refresh pulse, so it lags the write by one cycle.
  logic        armed_q;
  logic        fired_q;
  logic [15:0] cnt_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
      fired_q <= 1'b0;
      cnt_q   <= 16'h0000;
    end else begin
      armed_q <= armed_q | flags_update;
      fired_q <= flags_update ? 1'b0 : (fired_q | core_reset);
      cnt_q   <= flags_update ? 16'h0000 : cnt_q + {15'h0000, cnt_q != 16'hFFFF};
    end
  end
  // ====================
  // Properties
  // ====================
  write_answer_a: assert property (awvalid && wvalid && !bvalid |=> awready && wready && bvalid)
    else $error("write not answered");
  read_answer_a: assert property (arvalid && !rvalid |=> arready && rvalid)
    else $error("read not answered");
  bvalid_hold_a: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
  rvalid_hold_a: assert property (rvalid && !rready |=> $stable(rvalid)) else $error("rvalid dropped");
  ready_pulse_a: assert property (awready |=> !awready) else $error("awready held");
  wake_pulse_a: assert property (wake |=> !wake) else $error("wake held");
  refresh_pulse_a: assert property (flags_update |=> !flags_update)
    else $error("flag update held");
  reset_width_a: assert property ($rose(core_reset) |=> core_reset [*4])
    else $error("core reset too short");
  disabled_wd_a: assert property ($rose(core_reset) |-> armed_q)
    else $error("watchdog fired without refresh");
  retrigger_a: assert property (flags_update && !core_reset |=> !core_reset [*8])
    else $error("fired right after refresh");
  period_a: assert property ($rose(core_reset) && !fired_q |->
    cnt_q >= WD_CYC0 - 3 && cnt_q <= WD_CYC3 + 3) else $error("watchdog period off");
endmodule

// ===== bench/srw_pin_model.sv
/*
  Port pins seen by the wake logic.
  Assumes go is a one-cycle request; pins rest at the idle pattern.
*/
`timescale 1ns/1ps
`include "srw_defines.vh"
module srw_pin_model (
  input  logic       aclk,
  input  logic       go,
  input  logic [3:0] idle3,
  input  logic [3:0] act3,
  input  logic [7:0] idle2,
  input  logic [7:0] act2,
  output logic [3:0] port3_in,
  output logic [7:0] port2_in
);
  // ====================
  // Wake source hold
  // ====================
  // Extra cycles cover the two-flop synchroniser in front of the detector.
  int hold_q = 0;
  always @(posedge aclk) begin
    if (go) hold_q <= `SRW_FAST_HOLD + 5;
    else if (hold_q > 0) hold_q <= hold_q - 1;
  end
  assign port3_in = (hold_q > 0) ? act3 : idle3;
  assign port2_in = (hold_q > 0) ? act2 : idle2;
endmodule

// ===== bench/srw_tb_top.sv
/*
  Self-checking bench for srw_top over AXI4-Lite.
  Assumes shortened delay and watchdog counts set at the instance below.
*/
`timescale 1ns/1ps
module srw_tb_top;
  // ====================
  // Signals
  // ====================
  logic aclk = 0, aresetn = 0, por_n = 0, go = 0, xt = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0, i2 = 0, a2 = 0, p2o = 0, p2e = 0;
  logic [31:0] wdata = 0, rd_d;
  logic [3:0] wstrb = 0, i3 = 0, a3 = 0;
  logic [3:1] ana = 0;
  logic [1:0] rd_r;
  logic seen;
  wire awready, wready, bvalid, arready, rvalid, wake, core_reset, flags_update;
  wire clk_undivided, clk_div16;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] port3_in;
  wire [7:0] port2_in;
  int bad_count = 0, tests_run = 0, cyc = 0;
  srw_top #(.DELAY_CYC(20), .WD_CYC0(30), .WD_CYC1(40), .WD_CYC2(50), .WD_CYC3(60)) dut (
    .aclk, .aresetn, .por_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .port3_in, .port2_in, .port2_out(p2o), .port2_oe(p2e),
    .port3_analog(ana), .rc_tick(xt), .xtal_tick(xt), .wake, .core_reset,
    .flags_update, .clk_undivided, .clk_div16);
  srw_pin_model pins (.aclk, .go, .idle3(i3), .act3(a3), .idle2(i2), .act2(a2),
    .port3_in, .port2_in);
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  // ====================
  // Tasks
  // ====================
  task results;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic pa, pw, pb;
    pa = 1; pw = 1; pb = 1;
    awaddr <= a; wdata <= {24'h000000, d}; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (pa || pw || pb) begin
      @(posedge aclk);
      if (pa && awready === 1'b1) begin pa = 0; awvalid <= 1'b0; end
      if (pw && wready === 1'b1) begin pw = 0; wvalid <= 1'b0; end
      if (pb && bvalid === 1'b1) begin pb = 0; bready <= 1'b0; end
    end
    @(posedge aclk);
  endtask
  task rd(input logic [7:0] a);
    logic pa, pr;
    pa = 1; pr = 1;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (pa || pr) begin
      @(posedge aclk);
      if (pa && arready === 1'b1) begin pa = 0; arvalid <= 1'b0; end
      if (pr && rvalid === 1'b1) begin pr = 0; rready <= 1'b0; rd_d = rdata; rd_r = rresp; end
    end
    @(posedge aclk);
  endtask
  // Power-on is released first so its synchroniser settles before the bus reset ends.
  task rst(input logic p);
    aresetn <= 1'b0; por_n <= !p;
    repeat (4) @(posedge aclk);
    por_n <= 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  task wd(input int e);
    int n;
    n = 0;
    wr(8'h40, 8'h01);
    while (core_reset !== 1'b1 && n < 300) begin @(posedge aclk); n++; end
    chk("wd_period", 1, (n + 3 >= e - 4) && (n + 3 <= e + 4));
  endtask
  task st(input logic [7:0] r, x, input logic [3:0] j3, b3,
          input logic [7:0] j2, b2, e2, input logic ex, input int ml);
    int n;
    rst(0);
    i3 <= j3; i2 <= j2; a3 <= b3; a2 <= b2;
    wr(8'h30, x); wr(8'h2C, r); wr(8'h40, 8'h04);
    rd(8'h2C); chk("warm", 32'h80, rd_d[7:0]);
    p2e <= e2; go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    n = 0;
    while (wake !== 1'b1 && n < 80) begin @(posedge aclk); n++; end
    chk("wake", ex, n < 80);
    if (ex) chk("wake_lat", 1, ml > 0 ? n >= ml : n < 15);
    p2e <= 8'h00;
  endtask
  // ====================
  // Sequence
  // ====================
  // The crystal pin runs free at half the bus clock rate.
  always @(posedge aclk) xt <= ~xt;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    rst(1);
    rd(8'h2C); chk("recovery", 32'h0, rd_d[7:0]);
    rd(8'h44); chk("status", 32'h2, rd_d[7:0]);
    rd(8'h00); chk("unmapped", 32'h2, rd_r);
    chk("undivided", 0, clk_undivided);
    wr(8'h2C, 8'h02); chk("undivided", 1, clk_undivided);
    for (int k = 0; k < 5; k++) begin
      rst(0);
      if (k > 0) wr(8'h3C, 8'(k + 3));
      wd(k == 0 ? 40 : 20 + 10 * k);
    end
    rst(0);
    repeat (70) @(posedge aclk);
    wr(8'h3C, 8'h04);
    rd(8'h44); chk("window", 32'h0, rd_d[7:0]);
    wd(60);
    rst(0);
    wr(8'h3C, 8'h00); wr(8'h40, 8'h01); wr(8'h40, 8'h02);
    seen = 0;
    repeat (100) begin @(posedge aclk); if (core_reset === 1'b1) seen = 1; end
    chk("halt_wd", 0, seen);
    rst(0);
    wr(8'h3C, 8'h18); wr(8'h40, 8'h01); wr(8'h40, 8'h04);
    seen = 0;
    repeat (300) begin @(posedge aclk); if (core_reset === 1'b1) seen = 1; end
    chk("xtal_stop_wd", 0, seen);
    for (int c = 1; c < 6; c++)
      st(8'(8'h40 + 4 * c), 0, 0, c < 5 ? 4'(1 << (c - 1)) : 4'h0, 0,
         c == 5 ? 8'h80 : 8'h00, 0, 1, 0);
    st(8'h40, 0, 0, 4'hF, 0, 8'hFF, 0, 0, 0);
    st(8'h04, 0, 4'hF, 4'hE, 0, 0, 0, 1, 0);
    ana <= 3'b001;
    st(8'h48, 0, 0, 4'h2, 0, 0, 0, 0, 0);
    ana <= 3'b000;
    st(8'h18, 0, 0, 0, 8'hFF, 8'hF0, 0, 1, 0);
    st(8'h1C, 0, 0, 0, 8'hFF, 8'hF0, 0, 0, 0);
    st(8'h1C, 0, 0, 0, 8'hFF, 8'h00, 0, 1, 0);
    st(8'h1C, 0, 0, 0, 8'hFF, 8'hFF, 8'hFF, 1, 0);
    st(8'h00, 8'h01, 0, 0, 0, 8'h0F, 0, 1, 0);
    st(8'h00, 8'h02, 0, 0, 0, 8'h0F, 0, 0, 0);
    st(8'h00, 8'h02, 0, 0, 0, 8'hFF, 0, 1, 0);
    st(8'h64, 0, 0, 4'h1, 0, 0, 0, 1, 20);
    results();
  end
endmodule
bind srw_top srw_checker #(.WD_CYC0(WD_CYC0), .WD_CYC3(WD_CYC3)) u_chk (
  .aclk, .aresetn, .awvalid, .wvalid, .awready, .wready, .bvalid, .bready, .arvalid,
  .arready, .rvalid, .rready, .wake, .core_reset, .flags_update);
